//--- alcp_pkg.sv
// constants and register layout of the input level control parameter block
//==========================================================================
package alcp_pkg;

    //==========================================================================
    // clock and timing
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000;
    localparam int unsigned STEP_NORMAL_US  = 500;   // per-step time, normal mode
    localparam int unsigned STEP_LIMITER_US = 125;   // per-step time, limiter mode
    localparam int unsigned HOLD_TICK_US    = 1000;  // hold timer resolution, 1 ms
    localparam int unsigned STEP_NORMAL_CYC  = STEP_NORMAL_US * CLK_PER_US;
    localparam int unsigned STEP_LIMITER_CYC = STEP_LIMITER_US * CLK_PER_US;
    localparam int unsigned HOLD_TICK_CYC    = HOLD_TICK_US * CLK_PER_US;

    //==========================================================================
    // register indices (byte address = 4 * index)
    localparam logic [5:0] REG_CFG_IDX    = 6'h20;
    localparam logic [5:0] REG_TGT_IDX    = 6'h21;
    localparam logic [5:0] REG_MODE_IDX   = 6'h22;
    localparam logic [5:0] REG_STATUS_IDX = 6'h30;

    // field positions
    localparam int unsigned CH_SEL_LSB  = 7;   // level_control_config [8:7]
    localparam int unsigned CEIL_LSB    = 3;   // level_control_config [5:3]
    localparam int unsigned FLOOR_LSB   = 0;   // level_control_config [2:0]
    localparam int unsigned HOLD_LSB    = 4;   // level_control_target_hold [7:4]
    localparam int unsigned TARGET_LSB  = 0;   // level_control_target_hold [3:0]
    localparam int unsigned MODE_BIT    = 8;   // mode register [8]
    localparam int unsigned ST_GAIN_L   = 8;   // status [13:8] left gain
    localparam int unsigned ST_EXP_R    = 16;  // status [16] right hold expired
    localparam int unsigned ST_EXP_L    = 17;  // status [17] left hold expired

    // reset values
    localparam logic [8:0] CFG_RST  = 9'h038;
    localparam logic [8:0] TGT_RST  = 9'h00b;
    localparam logic [8:0] MODE_RST = 9'h000;
    localparam logic [5:0] GAIN_RST = 6'h10;   // 0 dB in 0.75 dB codes from -12 dB

    // gain and level encodings in 0.75 dB units; hold limits as a hold code and in ms
    localparam logic [5:0] CEIL_BASE       = 6'h07;  // -6.75 dB above -12 dB
    localparam logic [3:0] TARGET_CLAMP    = 4'he;   // 1110 and 1111 share -1.5 dBFS
    localparam logic [7:0] TARGET_ATT_BASE = 8'h1e;  // 22.5 dB below full scale
    localparam logic [3:0] HOLD_MAX_CODE   = 4'h9;   // 512 ms
    localparam logic [10:0] HOLD_CAP_MS    = 11'h3e8; // 1000 ms

endpackage : alcp_pkg

//--- alcp_hold_timer.sv
// hold timer that gates automatic gain increase for one channel
`timescale 1ns/1ps
module alcp_hold_timer
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ms_tick,
    input  wire logic       i_restart,
    input  wire logic [3:0] i_hold_code,
    output logic            o_expired
);
    import alcp_pkg::*;

    typedef struct packed {
        logic [10:0] ms_cnt;
        logic        expired;
    } alcp_hold_state_s;

    alcp_hold_state_s q;
    alcp_hold_state_s d;
    logic [10:0]      limit_ms;

    //==========================================================================
    // hold code to milliseconds: 0, then doubling from 2 ms, capped at 1000 ms
    function automatic logic [10:0] hold_ms(input logic [3:0] code);
        logic [10:0] r;
        r = 11'h000;
        if (code > HOLD_MAX_CODE)
            r = HOLD_CAP_MS;
        else if (code != 4'h0)
            r = 11'h001 << code;
        return r;
    endfunction : hold_ms

    //==========================================================================
    // ms ticks run free, so a hold may end up to 1 ms early; cheaper than a
    // private divider per channel
    always_comb
    begin
        limit_ms = hold_ms(i_hold_code);
        d        = q;
        if (i_restart)
        begin
            d.ms_cnt  = 11'h000;
            d.expired = (limit_ms == 11'h000);
        end
        else if (!q.expired && i_ms_tick)
        begin
            d.ms_cnt  = 11'(q.ms_cnt + 11'h001);
            d.expired = (11'(q.ms_cnt + 11'h001) >= limit_ms);
        end
        else if (limit_ms == 11'h000)
        begin
            d.expired = 1'b1;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            q <= '{ms_cnt: 11'h000, expired: 1'b1};
        else
            q <= d;
    end

    assign o_expired = q.expired;

endmodule : alcp_hold_timer

//--- alcp_level_ctl.sv
// input level control: parameter registers on avalon-mm and gain stepping
`timescale 1ns/1ps
module alcp_level_ctl
#(
    parameter int unsigned STEP_NORMAL_CYCLES  = alcp_pkg::STEP_NORMAL_CYC,
    parameter int unsigned STEP_LIMITER_CYCLES = alcp_pkg::STEP_LIMITER_CYC,
    parameter int unsigned HOLD_TICK_CYCLES    = alcp_pkg::HOLD_TICK_CYC
)
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic [7:0]  i_level_right,
    input  wire logic [7:0]  i_level_left,
    output logic [5:0]       o_gain_right,
    output logic [5:0]       o_gain_left,
    output logic             o_alc_active_right,
    output logic             o_alc_active_left,
    output logic             o_limiter_mode
);
    import alcp_pkg::*;

    localparam logic [16:0] STEP_N_M1 = 17'(STEP_NORMAL_CYCLES - 1);
    localparam logic [16:0] STEP_L_M1 = 17'(STEP_LIMITER_CYCLES - 1);
    localparam logic [16:0] TICK_M1   = 17'(HOLD_TICK_CYCLES - 1);

    typedef struct packed {
        logic [8:0]  cfg;
        logic [8:0]  tgt;
        logic [8:0]  mode;
        logic        ack;
        logic [31:0] rdata;
        logic [5:0]  gain_r;
        logic [5:0]  gain_l;
        logic [16:0] step_cnt;
        logic [16:0] ms_cnt;
        logic        step_tick;
        logic        ms_tick;
    } alcp_state_s;

    localparam alcp_state_s STATE_RST = '{
        cfg: CFG_RST, tgt: TGT_RST, mode: MODE_RST, ack: 1'b0, rdata: 32'h0000_0000,
        gain_r: GAIN_RST, gain_l: GAIN_RST, step_cnt: 17'h00000, ms_cnt: 17'h00000,
        step_tick: 1'b0, ms_tick: 1'b0};

    alcp_state_s q;
    alcp_state_s d;
    logic        req;
    logic [5:0]  idx;
    logic [1:0]  en;
    logic [5:0]  ceil_c;
    logic [5:0]  floor_c;
    logic [5:0]  lo_eff;
    logic [7:0]  t_att;
    logic        loud_r;
    logic        loud_l;
    logic        quiet_r;
    logic        quiet_l;
    logic        exp_r;
    logic        exp_l;
    logic [16:0] step_lim;

    //==========================================================================
    // field decoders
    function automatic logic [5:0] ceil_code(input logic [2:0] c);
        return 6'(CEIL_BASE + {c, 3'b000});
    endfunction : ceil_code

    function automatic logic [5:0] floor_code(input logic [2:0] c);
        return {c, 3'b000};
    endfunction : floor_code

    // target as attenuation below full scale, 2 units per 1.5 dB code
    function automatic logic [7:0] target_att(input logic [3:0] code);
        logic [3:0] c;
        c = (code > TARGET_CLAMP) ? TARGET_CLAMP : code;
        return 8'(TARGET_ATT_BASE - {3'b000, c, 1'b0});
    endfunction : target_att

    // byte lane 0 carries bits 7:0, lane 1 carries bit 8
    function automatic logic [8:0] apply_be(input logic [8:0] old, input logic [31:0] w,
                                            input logic [3:0] be);
        logic [8:0] r;
        r = old;
        if (be[0])
            r[7:0] = w[7:0];
        if (be[1])
            r[8] = w[8];
        return r;
    endfunction : apply_be

    // one channel's next gain: clamp first, then one 0.75 dB step per tick
    function automatic logic [5:0] next_gain(input logic [5:0] g, input logic on,
                                             input logic [5:0] hi, input logic [5:0] lo,
                                             input logic loud, input logic quiet,
                                             input logic expired, input logic tick);
        logic [5:0] r;
        r = g;
        if (on)
        begin
            if (g > hi)
                r = hi;
            else if (g < lo)
                r = lo;
            else if (tick && loud && (g > lo))
                r = g - 6'h01;
            else if (tick && quiet && expired && (g < hi))
                r = g + 6'h01;
        end
        return r;
    endfunction : next_gain

    //==========================================================================
    // decoded parameters and level comparison
    assign en      = q.cfg[CH_SEL_LSB +: 2];
    assign ceil_c  = ceil_code(q.cfg[CEIL_LSB +: 3]);
    assign floor_c = floor_code(q.cfg[FLOOR_LSB +: 3]);
    // a floor set above the ceiling would make the clamps fight; ceiling wins
    assign lo_eff  = (floor_c > ceil_c) ? ceil_c : floor_c;
    assign t_att   = target_att(q.tgt[TARGET_LSB +: 4]);
    assign loud_r  = (i_level_right < t_att);
    assign loud_l  = (i_level_left < t_att);
    assign quiet_r = (i_level_right > t_att);
    assign quiet_l = (i_level_left > t_att);

    //==========================================================================
    // hold timers, restarted while the channel is off or not below target
    alcp_hold_timer u_hold_right
    (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_ms_tick   (q.ms_tick),
        .i_restart   (!en[0] || !quiet_r),
        .i_hold_code (q.tgt[HOLD_LSB +: 4]),
        .o_expired   (exp_r)
    );

    alcp_hold_timer u_hold_left
    (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_ms_tick   (q.ms_tick),
        .i_restart   (!en[1] || !quiet_l),
        .i_hold_code (q.tgt[HOLD_LSB +: 4]),
        .o_expired   (exp_l)
    );

    //==========================================================================
    // next state: timebases, bus slave, gain engine
    assign req = i_avs_read || i_avs_write;
    assign idx = i_avs_address[7:2];

    always_comb
    begin
        step_lim    = q.mode[MODE_BIT] ? STEP_L_M1 : STEP_N_M1;
        d           = q;
        d.step_tick = 1'b0;
        d.ms_tick   = 1'b0;
        // >= so a switch to the shorter limiter period never overruns
        if (q.step_cnt >= step_lim)
        begin
            d.step_cnt  = 17'h00000;
            d.step_tick = 1'b1;
        end
        else
        begin
            d.step_cnt = 17'(q.step_cnt + 17'h00001);
        end
        if (q.ms_cnt >= TICK_M1)
        begin
            d.ms_cnt  = 17'h00000;
            d.ms_tick = 1'b1;
        end
        else
        begin
            d.ms_cnt = 17'(q.ms_cnt + 17'h00001);
        end
        // first cycle of a request latches read data, second one answers
        d.ack = req && !q.ack;
        if (req && !q.ack)
        begin
            case (idx)
                REG_CFG_IDX:    d.rdata = {23'h000000, q.cfg};
                REG_TGT_IDX:    d.rdata = {23'h000000, q.tgt};
                REG_MODE_IDX:   d.rdata = {23'h000000, q.mode[MODE_BIT], 8'h00};
                REG_STATUS_IDX: d.rdata = {14'h0000, exp_l, exp_r, 2'b00, q.gain_l,
                                           2'b00, q.gain_r};
                default:        d.rdata = 32'h0000_0000;
            endcase
        end
        if (i_avs_write && q.ack)
        begin
            case (idx)
                REG_CFG_IDX:  d.cfg  = apply_be(q.cfg, i_avs_writedata, i_avs_byteenable);
                REG_TGT_IDX:  d.tgt  = apply_be(q.tgt, i_avs_writedata, i_avs_byteenable);
                REG_MODE_IDX: d.mode = apply_be(q.mode, i_avs_writedata, i_avs_byteenable)
                                       & 9'h100;
                default:      d.mode = q.mode;
            endcase
        end
        d.gain_r = next_gain(q.gain_r, en[0], ceil_c, lo_eff, loud_r, quiet_r, exp_r,
                             q.step_tick);
        d.gain_l = next_gain(q.gain_l, en[1], ceil_c, lo_eff, loud_l, quiet_l, exp_l,
                             q.step_tick);
    end

    // state register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            q <= STATE_RST;
        else
            q <= d;
    end

    //==========================================================================
    // outputs
    assign o_avs_waitrequest  = req && !q.ack;
    assign o_avs_readdata     = q.rdata;
    assign o_gain_right       = q.gain_r;
    assign o_gain_left        = q.gain_l;
    assign o_alc_active_right = en[0];
    assign o_alc_active_left  = en[1];
    assign o_limiter_mode     = q.mode[MODE_BIT];

    //==========================================================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_req_new;
        req && o_avs_waitrequest;
    endsequence

    sequence s_cfg_write;
        i_avs_write && !o_avs_waitrequest && (idx == REG_CFG_IDX)
            && (i_avs_byteenable[1:0] == 2'b11);
    endsequence

    sequence s_in_range_r;
        en[0] && (q.gain_r <= ceil_c) && (q.gain_r >= lo_eff);
    endsequence

    a_bus_answer: assert property (s_req_new |=> !o_avs_waitrequest)
        else $error("request not answered on second cycle");

    a_unmapped_zero: assert property (s_req_new ##0 ((idx != REG_CFG_IDX)
            && (idx != REG_TGT_IDX) && (idx != REG_MODE_IDX) && (idx != REG_STATUS_IDX))
            |=> (o_avs_readdata == 32'h0000_0000))
        else $error("unmapped read not zero");

    a_chsel_write: assert property (s_cfg_write |=>
            (o_alc_active_right == $past(i_avs_writedata[7]))
            && (o_alc_active_left == $past(i_avs_writedata[8])))
        else $error("channel select not decoded from write");

    a_off_frozen: assert property (!en[0] |=> $stable(q.gain_r))
        else $error("disabled channel gain moved");

    a_gain_ceil: assert property ((en[0] && (q.gain_r <= ceil_c)) ##1 $stable(q.cfg)
            |-> (q.gain_r <= ceil_c))
        else $error("gain above ceiling");

    a_gain_floor: assert property ((en[0] && (q.gain_r >= lo_eff)) ##1 $stable(q.cfg)
            |-> (q.gain_r >= lo_eff))
        else $error("gain below floor");

    a_hold_gate: assert property (s_in_range_r ##0 !exp_r
            |=> (q.gain_r <= $past(q.gain_r)))
        else $error("gain rose before hold expired");

    a_target_dir: assert property (s_in_range_r ##0 loud_r
            |=> (q.gain_r <= $past(q.gain_r)))
        else $error("gain rose above target level");

    a_step_size: assert property (s_in_range_r |=> (q.gain_r == $past(q.gain_r))
            || (q.gain_r == 6'($past(q.gain_r) + 6'h01))
            || (q.gain_r == 6'($past(q.gain_r) - 6'h01)))
        else $error("gain step not one code");

    a_limiter_step: assert property (q.mode[MODE_BIT] && $past(q.mode[MODE_BIT])
            |-> (q.step_cnt <= STEP_L_M1))
        else $error("limiter step period exceeded");

endmodule : alcp_level_ctl

//--- alcp_level_ctl_tb.sv
// self-checking testbench for the input level control parameter block
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %0t: mismatch got %h expected %h", $time, (got), (exp)); end end
module alcp_level_ctl_tb;
    import alcp_pkg::*;

    //==========================================================================
    // stimulus and bookkeeping
    localparam int unsigned STEP_N = 8;   // shortened step period, normal mode
    localparam int unsigned STEP_L = 2;   // shortened step period, limiter mode
    localparam int unsigned TICK   = 4;   // shortened millisecond tick
    logic        i_sys_clk        = 1'b0;
    logic        i_rst            = 1'b1;
    logic [7:0]  i_avs_address    = 8'h00;
    logic        i_avs_read       = 1'b0;
    logic        i_avs_write      = 1'b0;
    logic [31:0] i_avs_writedata  = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'h3;
    logic [7:0]  i_level_right    = 8'h08;
    logic [7:0]  i_level_left     = 8'h08;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic [5:0]  o_gain_right;
    logic [5:0]  o_gain_left;
    logic        o_alc_active_right;
    logic        o_alc_active_left;
    logic        o_limiter_mode;
    int          n_errors = 0;
    int          compares = 0;
    int          cyc      = 0;
    logic [31:0] exp_q[$];
    logic [2:0]  c_code;
    logic [2:0]  f_code;
    logic [3:0]  t_tab[4] = '{4'h0, 4'hb, 4'he, 4'hf};
    int          att;
    logic [31:0] e_note;

    alcp_level_ctl #(.STEP_NORMAL_CYCLES(STEP_N), .STEP_LIMITER_CYCLES(STEP_L),
                     .HOLD_TICK_CYCLES(TICK)) uut
    (
        .i_sys_clk          (i_sys_clk),
        .i_rst              (i_rst),
        .i_avs_address      (i_avs_address),
        .i_avs_read         (i_avs_read),
        .i_avs_write        (i_avs_write),
        .i_avs_writedata    (i_avs_writedata),
        .i_avs_byteenable   (i_avs_byteenable),
        .o_avs_readdata     (o_avs_readdata),
        .o_avs_waitrequest  (o_avs_waitrequest),
        .i_level_right      (i_level_right),
        .i_level_left       (i_level_left),
        .o_gain_right       (o_gain_right),
        .o_gain_left        (o_gain_left),
        .o_alc_active_right (o_alc_active_right),
        .o_alc_active_left  (o_alc_active_left),
        .o_limiter_mode     (o_limiter_mode)
    );

    // 40 MHz clock and free cycle count
    always #12.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) cyc <= cyc + 1;

    //==========================================================================
    // read monitor: oldest note is compared when read data stand
    always @(posedge i_sys_clk)
    begin
        if (i_avs_read && o_avs_waitrequest === 1'b0)
        begin
            if (exp_q.size() == 0)
                `CHK(1'b1, 1'b0)
            else
            begin
                // pop once: the macro names its expected value twice
                e_note = exp_q.pop_front();
                `CHK(o_avs_readdata, e_note)
            end
        end
    end

    task automatic wrap_up();
        `CHK(exp_q.size(), 0)
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [8:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_avs_read       <= !wr;
        i_avs_write      <= wr;
        i_avs_address    <= a;
        i_avs_writedata  <= {23'h0, d};
        i_avs_byteenable <= be;
        do
        begin
            @(posedge i_sys_clk);
            n++;
        end
        while (o_avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) `CHK(1'b1, 1'b0)
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        exp_q.push_back({23'h0, e});
        bus(1'b0, a, 9'h0, 4'h3);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [8:0] d);
        bus(1'b1, a, d, 4'h3);
    endtask : wr

    task automatic lvl(input logic [7:0] v);
        @(posedge i_sys_clk);
        i_level_right <= v;
        i_level_left  <= v;
    endtask : lvl

    // bounded wait for both gains to settle on a value
    task automatic wait_gain(input logic [5:0] e, input int lim);
        int n;
        n = 0;
        while ((o_gain_right !== e || o_gain_left !== e) && n < lim)
        begin
            @(posedge i_sys_clk);
            n++;
        end
        `CHK(o_gain_right, e)
        `CHK(o_gain_left, e)
    endtask : wait_gain

    task automatic wait_chg();
        logic [5:0] g;
        int         n;
        g = o_gain_right;
        n = 0;
        while (o_gain_right === g && n < 40)
        begin
            @(posedge i_sys_clk);
            n++;
        end
    endtask : wait_chg

    // spacing and size of two successive falling steps
    task automatic steps(input int period);
        int         t1;
        logic [5:0] g;
        wait_chg();
        t1 = cyc;
        g  = o_gain_right;
        wait_chg();
        `CHK(cyc - t1, period)
        `CHK(o_gain_right, g - 6'h1)
    endtask : steps

    // gain direction for a level relative to the target
    task automatic dir_chk(input logic [7:0] v, input int d);
        logic [5:0] g0;
        logic       ok;
        lvl(v);
        repeat (2) @(posedge i_sys_clk);
        g0 = o_gain_right;
        repeat (3 * STEP_N) @(posedge i_sys_clk);
        ok = (d > 0) ? (o_gain_right > g0) : (d < 0) ? (o_gain_right < g0) : (o_gain_right == g0);
        `CHK(ok, 1'b1)
    endtask : dir_chk

    // hold before increase: loud spell restarts the timer, then quiet
    task automatic hold_chk(input logic [3:0] code);
        int         ms;
        int         n;
        logic [5:0] g0;
        ms = (code > 4'h9) ? 1000 : (1 << code);
        wr(8'h84, {1'b0, code, 4'hb});
        lvl(8'h00);
        repeat (16) @(posedge i_sys_clk);
        lvl(8'hff);
        @(posedge i_sys_clk);
        g0 = o_gain_right;
        n  = 0;
        while (o_gain_right === g0 && n < ms * TICK + 100)
        begin
            @(posedge i_sys_clk);
            n++;
        end
        `CHK(o_gain_right, g0 + 6'h1)
        `CHK(n >= (ms - 1) * TICK, 1'b1)
        `CHK(n <= ms * TICK + 2 * STEP_N + 4, 1'b1)
    endtask : hold_chk

    // watchdog sized well above the longest hold case
    initial
    begin
        repeat (60000) @(posedge i_sys_clk);
        n_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        wrap_up();
    end

    //==========================================================================
    // main sequence
    initial
    begin
        void'($urandom(11489));
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        `CHK(o_gain_right, GAIN_RST)
        `CHK(o_limiter_mode, 1'b0)
        rd(8'h80, CFG_RST);
        rd(8'h84, TGT_RST);
        rd(8'h88, MODE_RST);
        wr(8'hfc, 9'h1ff);
        rd(8'hfc, 9'h000);
        rd(8'h80, CFG_RST);
        // channel select codes, loud input so enabled gains fall
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h80, {2'(s), 7'h38});
            lvl(8'h00);
            repeat (2) @(posedge i_sys_clk);
            `CHK(o_alc_active_right, 1'(s))
            `CHK(o_alc_active_left, 1'(s >> 1))
            att = o_gain_right + 64 * o_gain_left;
            repeat (3 * STEP_N) @(posedge i_sys_clk);
            `CHK(o_gain_right < 6'(att), 1'(s))
            `CHK(o_gain_left < 6'(att / 64), 1'(s >> 1))
        end
        // random ceiling with quiet input, random floor with loud input
        c_code = 3'($urandom % 8);
        wr(8'h80, {3'b110, c_code, 3'b000});
        lvl(8'hff);
        wait_gain(CEIL_BASE + {c_code, 3'b000}, 600);
        repeat (30) @(posedge i_sys_clk);
        `CHK(o_gain_right, CEIL_BASE + {c_code, 3'b000})
        f_code = 3'($urandom % 8);
        wr(8'h80, {3'b110, 3'h7, f_code});
        lvl(8'h00);
        wait_gain({f_code, 3'b000}, 600);
        repeat (30) @(posedge i_sys_clk);
        `CHK(o_gain_left, {f_code, 3'b000})
        // step pacing in normal then limiter mode
        wr(8'h80, 9'h1b8);
        lvl(8'hff);
        wait_gain(6'h3f, 600);
        lvl(8'h00);
        steps(STEP_N);
        wr(8'h88, 9'h1ff);
        rd(8'h88, 9'h100);
        `CHK(o_limiter_mode, 1'b1)
        steps(STEP_L);
        wr(8'h88, 9'h000);
        hold_chk(4'h1);
        hold_chk(4'h9);
        hold_chk(4'hc);
        // target levels, both top codes share one level
        foreach (t_tab[i])
        begin
            wr(8'h84, {5'h00, t_tab[i]});
            att = 30 - 2 * ((t_tab[i] > 4'he) ? 14 : t_tab[i]);
            dir_chk(8'(att + 1), 1);
            dir_chk(8'(att - 1), -1);
            dir_chk(8'(att), 0);
        end
        // lane 1 disabled keeps bit 8 of the config register
        bus(1'b1, 8'h80, 9'h000, 4'h1);
        rd(8'h80, 9'h100);
        @(posedge i_sys_clk);
        `CHK(o_alc_active_left, 1'b1)
        `CHK(o_alc_active_right, 1'b0)
        // both channels on, ceiling code 0: gains clamp, zero hold keeps timers expired
        wr(8'h80, 9'h180);
        exp_q.push_back({14'h0000, 2'b11, 2'b00, CEIL_BASE, 2'b00, CEIL_BASE});
        bus(1'b0, 8'hc0, 9'h000, 4'h3);
        // let the monitor take the last note before the queue is checked
        @(posedge i_sys_clk);
        wrap_up();
    end

endmodule : alcp_level_ctl_tb
